// [rtl/dpc_host_port.sv]
`timescale 1ns/1ns
// host end of one port of the dual-port memory
module dpc_host_port
	import dpc_pkg::*;
#(
	parameter int APS = APS_CYC,
	parameter int FLAG = FLAG_CYC,
	parameter int WP = WP_CYC,
	parameter int ACC = ACC_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire dpc_req_s req,
	output logic reqReady,
	output logic rspValid,
	output logic [DATA_W-1:0] rspData,
	output logic contentionSeen,
	output dpc_pins_s portPins,
	input wire logic [DATA_W-1:0] portDataIn,
	output logic [DATA_W-1:0] portDataOut,
	output logic portDataOe,
	input wire logic portContention_n
);
	initial begin
		// settle time must also cover the arbitration setup lead
		if (APS < 1 || FLAG < APS || WP < 1 || ACC < 1
				|| FLAG > 255 || WP > 255 || ACC > 255) begin
			$error("dpc_host_port: timing counts out of range");
		end
	end

	typedef struct packed {
		dpc_state_e st;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rspValid;
		logic seen;
	} dpc_host_s;

	dpc_host_s s_r;
	dpc_host_s s_nxt;
	logic load;
	logic [7:0] loadVal;
	logic done;

	dpc_delay_count u_dpc_delay_count (
		.clk(clk),
		.rst_b(rst_b),
		.load(load),
		.loadVal(loadVal),
		.done(done)
	);

	////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.rspValid = 1'b0;
		s_nxt.seen = 1'b0;
		load = 1'b0;
		loadVal = CNT_ZERO;
		case (s_r.st)
			ST_IDLE: begin
				if (req.valid) begin
					s_nxt.write = req.write;
					s_nxt.addr = req.addr;
					s_nxt.wdata = req.wdata;
					s_nxt.st = ST_SETUP;
					// flag must settle before any write pulse
					load = 1'b1;
					loadVal = 8'(FLAG);
				end
			end
			ST_SETUP: begin
				// one flag input only: in an array the master's decision governs the word
				if (!portContention_n) begin
					// wait out the other side; restart the settle time afterwards
					s_nxt.seen = 1'b1;
					load = 1'b1;
					loadVal = 8'(FLAG);
				end else if (done) begin
					s_nxt.st = s_r.write ? ST_WRITE : ST_READ;
					load = 1'b1;
					loadVal = s_r.write ? 8'(WP) : 8'(ACC);
				end
			end
			ST_WRITE: begin
				if (done) begin
					s_nxt.st = ST_HOLD;
					s_nxt.rspValid = 1'b1;
				end
			end
			ST_READ: begin
				if (!portContention_n) begin
					// data untrustworthy while flagged: retry the access
					s_nxt.st = ST_SETUP;
					s_nxt.seen = 1'b1;
					load = 1'b1;
					loadVal = 8'(FLAG);
				end else if (done) begin
					s_nxt.rdata = portDataIn;
					s_nxt.rspValid = 1'b1;
					s_nxt.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// one idle cycle with the port deselected between accesses
				s_nxt.st = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{st: ST_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	wire active = (s_r.st == ST_SETUP) || (s_r.st == ST_WRITE) || (s_r.st == ST_READ);
	assign reqReady = (s_r.st == ST_IDLE);
	assign rspValid = s_r.rspValid;
	assign rspData = s_r.rdata;
	// pulse usable as an illegal-access interrupt source
	assign contentionSeen = s_r.seen;
	assign portPins = '{
		chipSel_n: !active,
		readWrite_n: !(s_r.st == ST_WRITE),
		outEn_n: !(s_r.st == ST_READ),
		addr: s_r.addr
	};
	assign portDataOut = s_r.wdata;
	assign portDataOe = (s_r.st == ST_WRITE);

	////////////////////////////////////////////////////////////////
	sequence s_flagged;
		!portContention_n && s_r.st == ST_SETUP;
	endsequence

	a_write_after_settle: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(s_r.st == ST_WRITE) |-> $past(s_r.st == ST_SETUP)
		&& $past(portContention_n))
		else $error("write pulse began without settle");
	a_stall_on_flag: assert property (@(posedge clk) disable iff (!rst_b)
		s_flagged |=> s_r.st == ST_SETUP && portPins.readWrite_n)
		else $error("host did not stall on contention");
	a_no_drive_on_read: assert property (@(posedge clk) disable iff (!rst_b)
		!portPins.outEn_n |-> !portDataOe)
		else $error("host drove data during read");
	a_deselect_idle: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_IDLE |-> portPins.chipSel_n && portPins.readWrite_n)
		else $error("idle port selected");
	localparam int WP_LAST = WP - 1;
	sequence s_write_start;
		$rose(s_r.st == ST_WRITE);
	endsequence
	sequence s_write_end;
		##WP_LAST !portPins.readWrite_n ##1 rspValid && portPins.readWrite_n;
	endsequence

	a_write_len: assert property (@(posedge clk) disable iff (!rst_b)
		s_write_start |-> s_write_end)
		else $error("write pulse length wrong");
	a_read_retry: assert property (@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_READ && !portContention_n |=> s_r.st == ST_SETUP && contentionSeen)
		else $error("flagged read not retried");
	a_read_resp: assert property (@(posedge clk) disable iff (!rst_b)
		rspValid |-> $past(s_r.st == ST_READ || s_r.st == ST_WRITE))
		else $error("response without access");
	a_addr_steady: assert property (@(posedge clk) disable iff (!rst_b)
		active && $past(active) |-> $stable(portPins.addr))
		else $error("address changed during access");
	a_data_oe_write: assert property (@(posedge clk) disable iff (!rst_b)
		portDataOe |-> !portPins.chipSel_n && !portPins.readWrite_n)
		else $error("data driven outside write");
endmodule : dpc_host_port

// [shared/dpc_pkg.sv]
// How it works
// - host stalls while its flag asserted, except during the write pulse
// - one master drives slave inhibits
// - hold address/select before write pulse
// - OR of flags may serve as interrupt
// - lead opposite port by 5 ns (not enforced: APS only bounds FLAG in the range check)
package dpc_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	// arbitration priority setup time, ns
	localparam int T_APS_NS = 5;
	localparam int CLK_NS = 4;
	localparam int APS_CYC = (T_APS_NS + CLK_NS - 1) / CLK_NS;
	// address/select settle before write pulse, ns (flag appearance allowance)
	localparam int T_FLAG_NS = 50;
	localparam int FLAG_CYC = (T_FLAG_NS + CLK_NS - 1) / CLK_NS;
	// write pulse width, ns
	localparam int T_WP_NS = 40;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	// read access, ns
	localparam int T_ACC_NS = 100;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WRITE, ST_READ, ST_HOLD} dpc_state_e;

	typedef struct packed {
		logic chipSel_n;
		logic readWrite_n;
		logic outEn_n;
		logic [ADDR_W-1:0] addr;
	} dpc_pins_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dpc_req_s;
endpackage : dpc_pkg

// [rtl/dpc_delay_count.sv]
`timescale 1ns/1ns
// down counter: load, then done pulses when it reaches one
module dpc_delay_count
	import dpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [7:0] loadVal,
	output logic done
);
	logic [7:0] cnt_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= CNT_ZERO;
		end else if (load) begin
			cnt_r <= loadVal;
		end else if (cnt_r != CNT_ZERO) begin
			cnt_r <= cnt_r - CNT_ONE;
		end
	end
	// no load term here: the caller's load depends on done, a term would close a loop
	assign done = (cnt_r == CNT_ONE);
endmodule : dpc_delay_count

// [verif/dpc_mem_model.sv]
`timescale 1ns/1ns
// dual-port memory: left faces the host, right is driven by the bench
module dpc_mem_model
	import dpc_pkg::*;
(
	input wire dpc_pins_s lPins,
	input wire logic [DATA_W-1:0] lDataIn,
	input wire logic lDataOe,
	output logic [DATA_W-1:0] lDataOut,
	output logic lContention_n,
	input wire logic lInhibit_n,
	input wire dpc_pins_s rPins,
	output logic [DATA_W-1:0] rDataOut,
	output logic rContention_n
);
	logic [DATA_W-1:0] mem [2048];
	time lT = 0;
	time rT = 0;
	logic match;
	always @(lPins.chipSel_n or lPins.addr) lT = $time;
	always @(rPins.chipSel_n or rPins.addr) rT = $time;
	assign match = !lPins.chipSel_n && !rPins.chipSel_n && lPins.addr == rPins.addr;
	// a tie flags the left side, so arbitration alone never takes both low
	// an outside inhibit, as a master's flag reaching a slave, also holds the left flag low
	assign lContention_n = !(match && lT >= rT) && lInhibit_n;
	assign rContention_n = !(match && lT < rT);
	always @* if (!lPins.chipSel_n && !lPins.readWrite_n && lDataOe && lContention_n)
		mem[lPins.addr] = lDataIn;
	// undriven pins show the inverse so a stale sample cannot pass
	always @* if (!lPins.chipSel_n && lPins.readWrite_n && !lPins.outEn_n && lContention_n)
		lDataOut = mem[lPins.addr];
	else
		lDataOut = ~mem[lPins.addr];
	assign rDataOut = rPins.chipSel_n ? ~mem[rPins.addr] : mem[rPins.addr];
endmodule : dpc_mem_model

// [verif/dpc_host_port_bench.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t mismatch", $time); end end
module dpc_host_port_bench
	import dpc_pkg::*;
;
	logic clk, rst_b, reqReady, rspValid, contentionSeen, portDataOe, lBusy_n, rBusy_n;
	logic inhibit_n;
	dpc_req_s req;
	dpc_pins_s portPins, rPins;
	logic [DATA_W-1:0] rspData, portDataIn, portDataOut, rData;
	int failures = 0, tests_run = 0, cycles = 0, seen = 0, a;
	int refMem[int];
	dpc_host_port #(.FLAG(2), .WP(1), .ACC(3)) u_dpc_host_port (.clk(clk), .rst_b(rst_b),
		.req(req), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.contentionSeen(contentionSeen), .portPins(portPins), .portDataIn(portDataIn),
		.portDataOut(portDataOut), .portDataOe(portDataOe), .portContention_n(lBusy_n));
	dpc_mem_model u_dpc_mem_model (.lPins(portPins), .lDataIn(portDataOut),
		.lDataOe(portDataOe), .lDataOut(portDataIn), .lContention_n(lBusy_n),
		.lInhibit_n(inhibit_n),
		.rPins(rPins), .rDataOut(rData), .rContention_n(rBusy_n));
	//////////
	task automatic give_verdict;
		$display("comparisons %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic access(input logic wr, input int ad, input int d);
		int n;
		n = 0;
		while (reqReady !== 1'b1) @(posedge clk);
		req <= '{1'b1, wr, ad[ADDR_W-1:0], d[DATA_W-1:0]};
		@(posedge clk);
		req.valid <= 1'b0;
		while (rspValid !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		`CHK(rspValid, 1'b1)
		if (wr) refMem[ad] = d;
		else `CHK(rspData, refMem[ad][DATA_W-1:0])
	endtask : access
	//////////
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (contentionSeen === 1'b1) seen++;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		rst_b = 0;
		inhibit_n = 1'b1;
		req = '0;
		rPins = '{1'b1, 1'b1, 1'b1, 11'h000};
		void'($urandom(66));
		repeat (2) @(posedge clk);
		rst_b <= 1;
		for (int i = 0; i < 24; i++) begin
			a = i == 0 ? 0 : i == 1 ? 2047 : $urandom_range(2047);
			access(1'b1, a, $urandom_range(255));
			access(1'b0, a, 0);
		end
		`CHK(portPins.chipSel_n, 1'b1)
		// right port settles well ahead of the host
		for (int w = 0; w < 2; w++) begin
			rPins <= '{1'b0, 1'b1, 1'b0, a[ADDR_W-1:0]};
			repeat (2) @(posedge clk);
			seen = 0;
			fork
				access(w[0], a, 8'h3C);
				begin
					repeat (30) @(posedge clk);
					`CHK(rData, refMem[a][DATA_W-1:0])
					`CHK(rBusy_n, 1'b1)
					`CHK(seen > 0, 1'b1)
					rPins <= '{1'b1, 1'b1, 1'b1, a[ADDR_W-1:0]};
				end
			join
			access(1'b0, a, 0);
		end
		// outside inhibit in mid-read must force a retry with good data
		seen = 0;
		fork
			access(1'b0, a, 0);
			begin
				while (portPins.outEn_n !== 1'b0) @(posedge clk);
				inhibit_n <= 1'b0;
				@(posedge clk);
				inhibit_n <= 1'b1;
			end
		join
		`CHK(seen > 0, 1'b1)
		// reset during the settle time: no write pulse, outputs idle
		while (reqReady !== 1'b1) @(posedge clk);
		req <= '{1'b1, 1'b1, a[ADDR_W-1:0], 8'hA5};
		@(posedge clk);
		req.valid <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		`CHK({portPins.chipSel_n, portPins.readWrite_n, portDataOe, reqReady}, 4'hD)
		`CHK(rspValid, 1'b0)
		rst_b <= 1'b1;
		access(1'b0, a, 0);
		give_verdict();
	end
endmodule : dpc_host_port_bench
